//--- tpp_pkg.sv
// Shared constants and helpers for the paired 8-bit pulse timers.
package tpp_pkg;

    // Mode register field positions.
    localparam int MODE_INIT_BIT = 0;
    localparam int MODE_DBUF_BIT = 1;
    localparam int MODE_OP_LSB = 2;
    localparam int MODE_EXT_BIT = 4;
    localparam int MODE_CLK_LSB = 5;

    // Widths.
    localparam int MODE_W = 8;
    localparam int CNT_W = 8;
    localparam int PRE_W = 11;

    // Operation-select encodings.
    localparam logic [1:0] OP_PPG = 2'h2;
    localparam logic [1:0] OP_T16A = 2'h0;
    localparam logic [1:0] OP_T16B = 2'h1;

    // Reset values.
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CNT8_RST = 8'h00;
    localparam logic [15:0] CNT16_RST = 16'h0000;
    localparam logic [7:0] CMP_RST = 8'hff;
    localparam logic [10:0] PRE_RST = 11'h000;

    typedef logic [7:0] tpp_byte_t;

    // Source clock strobe: the prescaler's low bits all at one; select 7 strobes every clock.
    function automatic logic tpp_tick(input logic [10:0] pre,
                                      input logic [2:0] sel);
        logic t;
        t = 1'b0;
        unique case (sel)
            3'h0: t = &pre[10:0];
            3'h1: t = &pre[9:0];
            3'h2: t = &pre[7:0];
            3'h3: t = &pre[5:0];
            3'h4: t = &pre[3:0];
            3'h5: t = &pre[1:0];
            3'h6: t = pre[0];
            3'h7: t = 1'b1;
        endcase
        return t;
    endfunction : tpp_tick

endpackage : tpp_pkg

//--- tpp_ch.sv
// One 8-bit programmable pulse channel with buffered compares.
`timescale 1ns/10ps
module tpp_ch (
    // Clock and reset
    input logic clk,
    input logic rst,
    // Channel control
    input logic en,
    input logic tick,
    input logic init_level,
    input logic dbuf_en,
    // Compare writes
    input logic duty_wr,
    input logic period_wr,
    input tpp_pkg::tpp_byte_t wdata,
    // State and events
    output tpp_pkg::tpp_byte_t count,
    output logic pulse_out,
    output logic irq,
    output tpp_pkg::tpp_byte_t duty_rd,
    output tpp_pkg::tpp_byte_t period_rd
);
    import tpp_pkg::*;

    tpp_byte_t cnt_reg, cnt_next;
    tpp_byte_t duty_buf_reg, duty_buf_next;
    tpp_byte_t duty_act_reg, duty_act_next;
    tpp_byte_t per_buf_reg, per_buf_next;
    tpp_byte_t per_act_reg, per_act_next;
    logic out_reg, out_next;
    logic irq_reg, irq_next;
    logic duty_done_reg, duty_done_next;
    logic per_done_reg, per_done_next;
    logic duty_hit, per_hit, direct;

    // Compares are checked every clock, so a value written equal to the
    // count matches at once instead of waiting for the next source tick.
    always_comb begin
        direct = !(dbuf_en && en); // RQ10 RQ13
        duty_buf_next = duty_wr ? wdata : duty_buf_reg; // RQ12
        per_buf_next = period_wr ? wdata : per_buf_reg; // RQ12
        duty_act_next = (duty_wr && direct) ? wdata : duty_act_reg; // RQ14
        per_act_next = (period_wr && direct) ? wdata : per_act_reg; // RQ14
        duty_hit = en && cnt_reg == duty_act_reg && !duty_done_reg; // RQ15
        per_hit = en && cnt_reg == per_act_reg && !per_done_reg; // RQ15
        cnt_next = cnt_reg;
        out_next = out_reg;
        irq_next = 1'b0;
        duty_done_next = duty_done_reg;
        per_done_next = per_done_reg;
        if (!en) begin
            cnt_next = CNT8_RST; // RQ9
            out_next = init_level; // RQ4 RQ9
            duty_done_next = 1'b0;
            per_done_next = 1'b0;
        end else if (per_hit) begin
            cnt_next = CNT8_RST; // RQ8
            out_next = init_level; // RQ7
            irq_next = 1'b1; // RQ7
            per_done_next = 1'b1;
            duty_done_next = 1'b0;
            if (dbuf_en) begin
                duty_act_next = duty_buf_next; // RQ11
                per_act_next = per_buf_next; // RQ11
            end
        end else begin
            if (duty_hit) begin
                out_next = ~init_level; // RQ6 RQ2
                duty_done_next = 1'b1;
            end
            if (tick) begin
                cnt_next = cnt_reg + 8'h01; // RQ6
                duty_done_next = 1'b0;
                per_done_next = 1'b0;
            end
        end
    end

    // Channel state registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= CNT8_RST;
            duty_buf_reg <= CMP_RST;
            duty_act_reg <= CMP_RST;
            per_buf_reg <= CMP_RST;
            per_act_reg <= CMP_RST;
            out_reg <= 1'b0;
            irq_reg <= 1'b0;
            duty_done_reg <= 1'b0;
            per_done_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            duty_buf_reg <= duty_buf_next;
            duty_act_reg <= duty_act_next;
            per_buf_reg <= per_buf_next;
            per_act_reg <= per_act_next;
            out_reg <= out_next;
            irq_reg <= irq_next;
            duty_done_reg <= duty_done_next;
            per_done_reg <= per_done_next;
        end
    end

    assign count = cnt_reg;
    assign pulse_out = out_reg;
    assign irq = irq_reg;
    assign duty_rd = duty_buf_reg;
    assign period_rd = per_buf_reg;

endmodule : tpp_ch

//--- tpp_top.sv
// Paired 8-bit pulse timers with a cascaded 16-bit interval mode.
// Operation
// (RQ1) Timer A pulse mode: op 10, no cascade.
// (RQ2) Duty compare sets width, period sets cycle.
// (RQ3) Run starts timer; mode writes then ignored.
// (RQ4) Stopped pin shows the initial-level bit.
// (RQ5) AND select drives pin with both outputs.
// (RQ6) Count per tick; duty match leaves idle.
// (RQ7) Period match restores idle, raises interrupt.
// (RQ8) Counter restarts from zero after period.
// (RQ9) Run cleared: stop, zero count, idle pin.
// (RQ10) Double-buffer bit governs both compares.
// (RQ11) Buffered running writes load at interrupt.
// (RQ12) Compare reads return buffered value.
// (RQ13) Stopped writes update buffer and active.
// (RQ14) Unbuffered writes act at once.
// (RQ15) Equal-to-count write matches immediately.
// (RQ16) Cascade joins timers; B settings rule.
// (RQ17) Interval mode: B op 00/01, no ext.
// (RQ18) Low byte then high; high commits.
// (RQ19) B run starts 16-bit; mode locked.
// (RQ20) 16-bit match: B interrupt, count cleared.
// (RQ21) B run cleared: stop, clear 16-bit.
// (RQ22) Buffered pair loads at next match.
// (RQ23) Stopped pair loads buffer and active.
// (RQ24) Timer B offers identical pulse mode.
`timescale 1ns/10ps
module tpp_top (
    // Clock and reset
    input logic clk,
    input logic rst,
    // Pair control bits
    input logic timer_a_run,
    input logic timer_b_run,
    input logic cascade_select,
    input logic and_output_sel,
    // Mode register writes
    input logic timer_a_mode_wr,
    input logic timer_b_mode_wr,
    input tpp_pkg::tpp_byte_t mode_wdata,
    // Compare register writes
    input logic timer_a_duty_wr,
    input logic timer_a_period_wr,
    input logic timer_b_duty_wr,
    input logic timer_b_match_wr,
    input tpp_pkg::tpp_byte_t cmp_wdata,
    // Register readback
    output tpp_pkg::tpp_byte_t timer_a_mode_rd,
    output tpp_pkg::tpp_byte_t timer_b_mode_rd,
    output tpp_pkg::tpp_byte_t timer_a_duty_rd,
    output tpp_pkg::tpp_byte_t timer_a_period_rd,
    output tpp_pkg::tpp_byte_t timer_b_duty_rd,
    output tpp_pkg::tpp_byte_t timer_b_match_rd,
    output logic [15:0] combined_match_rd,
    // Counter state
    output tpp_pkg::tpp_byte_t timer_a_count,
    output tpp_pkg::tpp_byte_t timer_b_count,
    output logic [15:0] cascade_count,
    // Pins and events
    output logic pulse_out_pin,
    output logic timer_b_pulse_out,
    output logic timer_a_irq,
    output logic timer_b_irq
);
    import tpp_pkg::*;

    tpp_byte_t timer_a_mode_reg, timer_a_mode_next;
    tpp_byte_t timer_b_mode_reg, timer_b_mode_next;
    logic [10:0] pre_reg, pre_next;
    logic [15:0] c_cnt_reg, c_cnt_next;
    logic [15:0] c_buf_reg, c_buf_next;
    logic [15:0] c_act_reg, c_act_next;
    logic c_done_reg, c_done_next;
    logic c_irq_reg, c_irq_next;
    logic pin_reg, pin_next;
    logic b_pin_reg, b_pin_next;
    logic a_en, b_en, c_en, c_hit, c_commit;
    logic a_tick, b_tick;
    logic a_out, b_out, a_irq, b_irq;
    logic [1:0] a_op, b_op;
    tpp_byte_t a_period_buf;

    // Field decode of the two mode registers.
    assign a_op = timer_a_mode_reg[MODE_OP_LSB +: 2];
    assign b_op = timer_b_mode_reg[MODE_OP_LSB +: 2];

    // Mode registers lock while their timer runs, so a stray write cannot
    // change the clock or compare behaviour in the middle of a cycle.
    always_comb begin
        timer_a_mode_next = timer_a_mode_reg;
        timer_b_mode_next = timer_b_mode_reg;
        if (timer_a_mode_wr && !timer_a_run) begin
            timer_a_mode_next = mode_wdata; // RQ3
        end
        if (timer_b_mode_wr && !timer_b_run) begin
            timer_b_mode_next = mode_wdata; // RQ19
        end
    end

    // Mode register storage.
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_a_mode_reg <= MODE_RST;
            timer_b_mode_reg <= MODE_RST;
        end else begin
            timer_a_mode_reg <= timer_a_mode_next;
            timer_b_mode_reg <= timer_b_mode_next;
        end
    end

    // Free-running prescaler shared by both timers.
    always_comb begin
        pre_next = pre_reg + 11'h001;
    end

    // Prescaler register; its phase is not reset by run, so the first
    // source tick after a start can come early by up to one period.
    always_ff @(posedge clk) begin
        if (rst) begin
            pre_reg <= PRE_RST;
        end else begin
            pre_reg <= pre_next;
        end
    end

    // Source clock strobes picked by each timer's clock select field.
    assign a_tick = tpp_tick(pre_reg,
        timer_a_mode_reg[MODE_CLK_LSB +: 3]); // RQ1
    assign b_tick = tpp_tick(pre_reg,
        timer_b_mode_reg[MODE_CLK_LSB +: 3]); // RQ17

    // Mode qualification; in cascade both pulse channels are held off
    // and only timer B's settings matter.
    assign a_en = timer_a_run && !cascade_select && a_op == OP_PPG
        && !timer_a_mode_reg[MODE_EXT_BIT]; // RQ1 RQ3
    assign b_en = timer_b_run && !cascade_select && b_op == OP_PPG
        && !timer_b_mode_reg[MODE_EXT_BIT]; // RQ24
    assign c_en = timer_b_run && cascade_select
        && (b_op == OP_T16A || b_op == OP_T16B)
        && !timer_b_mode_reg[MODE_EXT_BIT]; // RQ16 RQ17 RQ19

    // Timer A pulse channel; its period buffer also stages the low byte
    // of the 16-bit compare, since the channel is idle in cascade.
    tpp_ch u_ch_a (
        .clk(clk),
        .rst(rst),
        .en(a_en),
        .tick(a_tick),
        .init_level(timer_a_mode_reg[MODE_INIT_BIT]),
        .dbuf_en(timer_a_mode_reg[MODE_DBUF_BIT]),
        .duty_wr(timer_a_duty_wr),
        .period_wr(timer_a_period_wr),
        .wdata(cmp_wdata),
        .count(timer_a_count),
        .pulse_out(a_out),
        .irq(a_irq),
        .duty_rd(timer_a_duty_rd),
        .period_rd(a_period_buf)
    );

    // Timer B pulse channel, same behaviour with its own resources.
    tpp_ch u_ch_b (
        .clk(clk),
        .rst(rst),
        .en(b_en),
        .tick(b_tick),
        .init_level(timer_b_mode_reg[MODE_INIT_BIT]),
        .dbuf_en(timer_b_mode_reg[MODE_DBUF_BIT]),
        .duty_wr(timer_b_duty_wr),
        .period_wr(timer_b_match_wr),
        .wdata(cmp_wdata),
        .count(timer_b_count),
        .pulse_out(b_out),
        .irq(b_irq),
        .duty_rd(timer_b_duty_rd),
        .period_rd(timer_b_match_rd)
    ); // RQ24

    // Cascade commit: the high byte write carries the staged low byte.
    assign c_commit = timer_b_match_wr && cascade_select; // RQ18

    // The 16-bit counter compares every clock, like the 8-bit channels,
    // so an equal-valued commit matches straight away.
    always_comb begin
        c_buf_next = c_buf_reg;
        c_act_next = c_act_reg;
        if (c_commit) begin
            c_buf_next = {cmp_wdata, a_period_buf}; // RQ18
            if (!(timer_b_mode_reg[MODE_DBUF_BIT] && c_en)) begin
                c_act_next = c_buf_next; // RQ23
            end
        end
        c_hit = c_en && c_cnt_reg == c_act_reg && !c_done_reg;
        c_cnt_next = c_cnt_reg;
        c_done_next = c_done_reg;
        c_irq_next = 1'b0;
        if (!c_en) begin
            c_cnt_next = CNT16_RST; // RQ21
            c_done_next = 1'b0;
        end else if (c_hit) begin
            c_cnt_next = CNT16_RST; // RQ20
            c_irq_next = 1'b1; // RQ20
            c_done_next = 1'b1;
            if (timer_b_mode_reg[MODE_DBUF_BIT]) begin
                c_act_next = c_buf_next; // RQ22
            end
        end else if (b_tick) begin
            c_cnt_next = c_cnt_reg + 16'h0001;
            c_done_next = 1'b0;
        end
    end

    // Cascade state registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            c_cnt_reg <= CNT16_RST;
            c_buf_reg <= {CMP_RST, CMP_RST};
            c_act_reg <= {CMP_RST, CMP_RST};
            c_done_reg <= 1'b0;
            c_irq_reg <= 1'b0;
        end else begin
            c_cnt_reg <= c_cnt_next;
            c_buf_reg <= c_buf_next;
            c_act_reg <= c_act_next;
            c_done_reg <= c_done_next;
            c_irq_reg <= c_irq_next;
        end
    end

    // Pin selection; the AND path is what builds carrier-style bursts
    // out of a fast timer gated by a slow one.
    always_comb begin
        pin_next = and_output_sel ? (a_out & b_out) : a_out; // RQ5
        b_pin_next = b_out;
    end

    // Pin registers keep the outputs glitch free across the AND gate.
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_reg <= 1'b0;
            b_pin_reg <= 1'b0;
        end else begin
            pin_reg <= pin_next;
            b_pin_reg <= b_pin_next;
        end
    end

    // Outputs.
    assign pulse_out_pin = pin_reg;
    assign timer_b_pulse_out = b_pin_reg;
    assign timer_a_irq = a_irq;
    assign timer_b_irq = b_irq | c_irq_reg; // RQ20
    assign timer_a_mode_rd = timer_a_mode_reg;
    assign timer_b_mode_rd = timer_b_mode_reg;
    assign timer_a_period_rd = a_period_buf;
    assign combined_match_rd = c_buf_reg;
    assign cascade_count = c_cnt_reg;

endmodule : tpp_top

//--- tpp_asserts.sv
// Concurrent checks on the paired pulse timers.
`timescale 1ns/10ps
module tpp_asserts (
    // Clock, reset and controls
    input logic clk,
    input logic rst,
    input logic timer_a_run,
    input logic timer_b_run,
    input logic cascade_select,
    input logic and_output_sel,
    input logic timer_a_mode_wr,
    input logic timer_b_mode_wr,
    input logic timer_a_duty_wr,
    input logic timer_b_match_wr,
    input tpp_pkg::tpp_byte_t cmp_wdata,
    // Observed outputs
    input tpp_pkg::tpp_byte_t timer_a_mode_rd,
    input tpp_pkg::tpp_byte_t timer_b_mode_rd,
    input tpp_pkg::tpp_byte_t timer_a_duty_rd,
    input tpp_pkg::tpp_byte_t timer_a_period_rd,
    input logic [15:0] combined_match_rd,
    input tpp_pkg::tpp_byte_t timer_a_count,
    input logic [15:0] cascade_count,
    input logic pulse_out_pin,
    input logic timer_a_irq,
    input logic timer_b_irq
);
    import tpp_pkg::*;

    // One domain, so clock and reset are declared once.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Period match strobes once and lands on the counter wrap.
    a_irq_one_cycle: assert property (timer_a_irq |=> !timer_a_irq)
        else $error("timer A interrupt held too long");
    a_irq_count_zero: assert property (
        timer_a_irq |-> timer_a_count == 8'h00)
        else $error("timer A interrupt without counter wrap");
    // A dropped run bit zeroes the count one edge later.
    a_stop_clears_a: assert property (
        !timer_a_run && !cascade_select |=> timer_a_count == 8'h00)
        else $error("timer A count not cleared on stop");
    a_stop_clears_c: assert property (
        !timer_b_run |=> cascade_count == 16'h0000)
        else $error("cascade count not cleared on stop");
    // A wrap from a nonzero count while running is a match.
    a_casc_wrap_irq: assert property (
        cascade_select && timer_b_run && $past(timer_b_run)
        && $past(cascade_count) != 16'h0000 && cascade_count == 16'h0000
        |-> timer_b_irq)
        else $error("cascade wrap without interrupt");
    // Mode writes while running are refused.
    a_mode_lock_a: assert property (
        timer_a_run && timer_a_mode_wr |=> $stable(timer_a_mode_rd))
        else $error("timer A mode changed while running");
    a_mode_lock_b: assert property (
        timer_b_run && timer_b_mode_wr |=> $stable(timer_b_mode_rd))
        else $error("timer B mode changed while running");
    a_duty_readback: assert property (
        timer_a_duty_wr |=> timer_a_duty_rd == $past(cmp_wdata))
        else $error("duty readback is not the last write");
    // The high write commits the staged low byte with it.
    a_pair_commit: assert property (
        timer_b_match_wr && cascade_select |=> combined_match_rd
        == {$past(cmp_wdata), $past(timer_a_period_rd)})
        else $error("combined compare not committed");
    // The pin register lags the channel, so idle is judged after 3 edges.
    a_idle_level: assert property (
        (!timer_a_run && !and_output_sel && !cascade_select
        && $stable(timer_a_mode_rd)) [*3]
        |-> pulse_out_pin == timer_a_mode_rd[MODE_INIT_BIT])
        else $error("stopped pin differs from initial level");
endmodule : tpp_asserts

bind tpp_top tpp_asserts u_tpp_asserts (
    .clk(clk), .rst(rst), .timer_a_run(timer_a_run),
    .timer_b_run(timer_b_run), .cascade_select(cascade_select),
    .and_output_sel(and_output_sel), .timer_a_mode_wr(timer_a_mode_wr),
    .timer_b_mode_wr(timer_b_mode_wr), .timer_a_duty_wr(timer_a_duty_wr),
    .timer_b_match_wr(timer_b_match_wr), .cmp_wdata(cmp_wdata),
    .timer_a_mode_rd(timer_a_mode_rd), .timer_b_mode_rd(timer_b_mode_rd),
    .timer_a_duty_rd(timer_a_duty_rd),
    .timer_a_period_rd(timer_a_period_rd),
    .combined_match_rd(combined_match_rd), .timer_a_count(timer_a_count),
    .cascade_count(cascade_count), .pulse_out_pin(pulse_out_pin),
    .timer_a_irq(timer_a_irq), .timer_b_irq(timer_b_irq)
);

//--- tpp_top_tb_top.sv
// Self-checking bench for the paired pulse timers.
`timescale 1ns/10ps
module tpp_top_tb_top;
    import tpp_pkg::*;

    // Stimulus and observed outputs.
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic run_a = 1'b0;
    logic run_b = 1'b0;
    logic casc = 1'b0;
    logic and_sel = 1'b0;
    logic [5:0] we = 6'h00;
    tpp_byte_t mdat = 8'h00;
    tpp_byte_t cdat = 8'h00;
    tpp_byte_t a_mode, b_mode, a_per, b_match, a_cnt, b_cnt, d, p;
    tpp_byte_t a_duty, b_duty;
    logic [15:0] cm_rd, c_cnt;
    logic pin, b_out, a_irq, b_irq;
    int errors = 0;
    int cmp_count = 0;
    int cyc_n = 0, act_n = 0, n_last = 0, a_last = 0, irqs = 0;
    logic msel = 1'b0;
    logic mlvl = 1'b0;

    tpp_top u_tpp_top (
        .clk(clk), .rst(rst), .timer_a_run(run_a), .timer_b_run(run_b),
        .cascade_select(casc), .and_output_sel(and_sel),
        .timer_a_mode_wr(we[0]), .timer_b_mode_wr(we[1]), .mode_wdata(mdat),
        .timer_a_duty_wr(we[2]), .timer_a_period_wr(we[3]),
        .timer_b_duty_wr(we[4]), .timer_b_match_wr(we[5]), .cmp_wdata(cdat),
        .timer_a_mode_rd(a_mode), .timer_b_mode_rd(b_mode),
        .timer_a_duty_rd(a_duty), .timer_a_period_rd(a_per),
        .timer_b_duty_rd(b_duty), .timer_b_match_rd(b_match),
        .combined_match_rd(cm_rd), .timer_a_count(a_cnt),
        .timer_b_count(b_cnt), .cascade_count(c_cnt),
        .pulse_out_pin(pin), .timer_b_pulse_out(b_out),
        .timer_a_irq(a_irq), .timer_b_irq(b_irq)
    );

    // Clock at 40 MHz.
    always #12.5 clk = ~clk;

    // Irq spacing and active cycles are taken at the falling edge, where
    // registered outputs have settled.
    always @(negedge clk) begin
        if ((msel ? b_irq : a_irq) === 1'b1) begin
            n_last <= cyc_n + 1;
            a_last <= act_n + int'((msel ? b_out : pin) !== mlvl);
            cyc_n <= 0;
            act_n <= 0;
            irqs <= irqs + 1;
        end else begin
            cyc_n <= cyc_n + 1;
            act_n <= act_n + int'((msel ? b_out : pin) !== mlvl);
        end
    end

    task automatic stop_test();
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // Cycles between two period matches: the match value plus the wrap.
    function automatic logic [15:0] span(input logic [15:0] n);
        return n + 16'h0001;
    endfunction : span

    // Index: 0/1 mode A/B, 2/3 duty/period A, 4/5 duty/match B.
    task automatic wr(input int i, input tpp_byte_t v);
        @(posedge clk);
        we <= 6'(1 << i);
        mdat <= v;
        cdat <= v;
        @(posedge clk);
        we <= 6'h00;
    endtask : wr

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : settle

    // Bounded so that a channel that never strobes ends the run.
    task automatic wait_irq(input int k);
        int s;
        s = irqs;
        for (int i = 0; i < 3000 && irqs < s + k; i++) begin
            @(posedge clk);
        end
        if (irqs < s + k) begin
            errors++;
            stop_test();
        end
    endtask : wait_irq

    task automatic start(input logic b, input tpp_byte_t m,
                         input tpp_byte_t dv, input tpp_byte_t pv);
        wr(int'(b), m);
        wr(2 + 2 * int'(b), dv);
        wr(3 + 2 * int'(b), pv);
        settle(3);
        chk(b ? b_out : pin, m[MODE_INIT_BIT]);
        msel = b;
        mlvl = m[MODE_INIT_BIT];
        @(posedge clk);
        run_a <= !b;
        run_b <= b;
    endtask : start

    // Pulse run, locked mode write, then a period rewrite after a match.
    task automatic ppg(input logic b, input logic db, input tpp_byte_t dv,
                       input tpp_byte_t pv, input tpp_byte_t p2, input int e2);
        tpp_byte_t m;
        m = {3'h7, 1'b0, OP_PPG, db, 1'($urandom)};
        start(b, m, dv, pv);
        chk(b ? b_duty : a_duty, dv);
        wait_irq(2);
        chk(16'(n_last), span(16'(pv)));
        chk(16'(a_last), 16'(pv - dv));
        wr(int'(b), ~m);
        settle(1);
        chk(b ? b_mode : a_mode, m);
        wait_irq(1);
        wr(3 + 2 * int'(b), p2);
        wait_irq(1);
        chk(16'(n_last), db ? span(16'(pv)) : 16'(e2));
        chk(b ? b_match : a_per, p2);
        if (db) begin
            wait_irq(1);
            chk(16'(n_last), span(16'(p2)));
        end
        run_a <= 1'b0;
        run_b <= 1'b0;
        settle(2);
        chk(b ? b_cnt : a_cnt, 8'h00);
        chk(b ? b_out : pin, mlvl);
    endtask : ppg

    // Timer B held stopped at level bl gates the pin.
    task automatic andt(input logic bl, input int e);
        wr(1, {3'h7, 1'b0, OP_PPG, 1'b0, bl});
        and_sel <= 1'b1;
        start(1'b0, {3'h7, 1'b0, OP_PPG, 2'b00}, d, p);
        wait_irq(2);
        chk(16'(a_last), 16'(e));
        run_a <= 1'b0;
        and_sel <= 1'b0;
        settle(2);
    endtask : andt

    // Cascade with timer A also set running, which must be ignored.
    task automatic casc_t(input logic [1:0] op, input logic db,
                          input logic [15:0] v, input logic [15:0] v2);
        @(posedge clk);
        casc <= 1'b1;
        wr(1, {3'h7, 1'b0, op, db, 1'b0});
        wr(3, v[7:0]);
        wr(5, v[15:8]);
        settle(1);
        chk(cm_rd, v);
        msel = 1'b1;
        @(posedge clk);
        run_b <= 1'b1;
        run_a <= 1'b1;
        wait_irq(2);
        chk(16'(n_last), span(v));
        chk(a_cnt, 8'h00);
        wait_irq(1);
        wr(3, v2[7:0]);
        wr(5, v2[15:8]);
        wait_irq(1);
        chk(16'(n_last), span(db ? v : v2));
        wait_irq(1);
        chk(16'(n_last), span(v2));
        run_a <= 1'b0;
        run_b <= 1'b0;
        settle(2);
        chk(c_cnt, 16'h0000);
        @(posedge clk);
        casc <= 1'b0;
        settle(3);
    endtask : casc_t

    // Main sequence: corners first, then random pulse and cascade runs.
    initial begin
        void'($urandom(32'h57eb4901));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        ppg(1'b0, 1'b0, 8'h01, 8'hff, 8'h10, 17);
        ppg(1'b0, 1'b0, 8'h03, 8'h20, 8'h01, 258);
        for (int i = 0; i < 4; i++) begin
            d = 8'(1 + $urandom % 60);
            p = 8'(d + 1 + $urandom % 60);
            ppg(i[0], i[1], d, p, 8'(p + 8'h08), int'(p) + 9);
        end
        andt(1'b0, 0);
        andt(1'b1, int'(p - d));
        for (int i = 0; i < 2; i++) begin
            casc_t(i[0] ? OP_T16B : OP_T16A, i[0],
                   16'h0100 | 16'($urandom % 256),
                   16'h0040 | 16'($urandom % 256));
        end
        stop_test();
    end
endmodule : tpp_top_tb_top
